// ### hdl/cfsm_pkg.sv
// Constants, types and register map of the clock fail-safe monitor.
// Assumes a single core clock; used by cfsm_monitor and its bench.
`default_nettype none
package cfsm_pkg;
   // Register indices; byte address is four times the index
   localparam logic [15:0] IDX_IRQ_FLAGS = 16'h000c;
   localparam logic [15:0] IDX_IRQ_ENABLES = 16'h008c;
   localparam logic [15:0] IDX_OSC_CONTROL = 16'h008f;
   localparam logic [15:0] IDX_OSC_TRIM = 16'h0090;
   localparam logic [15:0] IDX_CONFIG_WORD = 16'h2007;
   // Field positions
   localparam int OSC_FAIL_BIT = 2;
   localparam int FREQ_LSB = 4;
   localparam int EXT_ACTIVE_BIT = 3;
   localparam int HF_STABLE_BIT = 2;
   localparam int LF_STABLE_BIT = 1;
   localparam int SYS_SEL_BIT = 0;
   localparam int TRIM_W = 5;
   // Reset values
   localparam logic [2:0] FREQ_RST = 3'b110;
   localparam logic [7:0] REG_RST = 8'h00;
   // Timing counts
   localparam int OST_EDGES = 1024;
   localparam int SAMPLE_DIV = 64;
   // Clock source config codes (crystal modes are the three lowest)
   localparam logic [2:0] LOW_POWER_CRYSTAL_MODE = 3'b000;
   localparam logic [2:0] STD_CRYSTAL_MODE = 3'b001;
   localparam logic [2:0] HIGH_SPEED_CRYSTAL_MODE = 3'b010;
   localparam logic [2:0] EXT_CLOCK_INPUT_MODE = 3'b011;

   // Internal oscillator frequency select codes
   typedef enum logic [2:0] {
      FREQ_31K = 3'b000, FREQ_125K = 3'b001, FREQ_250K = 3'b010,
      FREQ_500K = 3'b011, FREQ_1M = 3'b100, FREQ_2M = 3'b101,
      FREQ_4M = 3'b110, FREQ_8M = 3'b111
   } cfsm_freq_e;

   // Monitor states
   typedef enum logic [3:0] {
      ST_START = 4'b0001,
      ST_RUN = 4'b0010,
      ST_FAIL = 4'b0100,
      ST_SLEEP = 4'b1000
   } cfsm_state_e;

   // Fuse settings seen by the block
   typedef struct packed {
      logic       two_speed_en;
      logic       fail_mon_en;
      logic [7:0] word;
   } cfsm_cfg_s;

   // System clock steering towards the clock mux
   typedef struct packed {
      logic       use_internal;
      logic       hold;
      cfsm_freq_e freq;
   } cfsm_clk_s;
endpackage : cfsm_pkg
`default_nettype wire

// ### hdl/cfsm_monitor.sv
// Clock fail-safe monitor with oscillator control registers.
// Assumes: external clock falling edges and LF oscillator ticks arrive as
// one-cycle pulses synchronous to core_clk; Avalon-MM master on the bus.
//
// How it works
// - Any reset, a sleep instruction or a write that changes sys_clock_select ends fail-safe.
// - In fail-safe the system clock comes from the internal oscillator.
// - Writing int_osc_freq_sel in fail-safe changes frequency but keeps fail-safe.
// - osc_fail_flag cannot be cleared until fail-safe has ended.
// - Failure is detected only after reset or sleep and, in crystal modes, after the start-up count.
// - In external clock or RC mode monitoring starts straight after reset or sleep.
// - In crystal modes with two_speed_en or fail_mon_en set the internal oscillator runs the system until start-up ends; otherwise the clock is held.
// - Once the external oscillator is stable the LF oscillator drives the sampler.
// - Detection stays off during oscillator start-up.
// - ext_clock_active_flag is 1 on the external clock and 0 on an internal one.
// - hf_osc_stable_flag is 1 while the HF oscillator is stable.
// - ext_clock_active_flag resets to 0.
// - After reset int_osc_freq_sel holds 110 for 4 MHz.
// - sys_clock_select 1 picks the internal oscillator, 0 the configured source.
// - A failure sets osc_fail_flag and interrupts when osc_fail_irq_enable is set.
`default_nettype none
module cfsm_monitor (
   // Clock and reset
   input  wire logic              core_clk,
   input  wire logic              rst,
   // Avalon-MM slave
   input  wire logic [15:0]       address,
   input  wire logic              read,
   input  wire logic              write,
   input  wire logic [31:0]       writedata,
   output logic [31:0]            readdata,
   output logic                   waitrequest,
   // Clock events and status
   input  wire logic              ext_clk_fall,
   input  wire logic              lf_osc_tick,
   input  wire logic              hf_osc_ready,
   input  wire logic              lf_osc_ready,
   input  wire logic              sleep_exec,
   input  wire logic              wake_up,
   input  wire cfsm_pkg::cfsm_cfg_s cfg,
   // Clock steering, trim and interrupt
   output cfsm_pkg::cfsm_clk_s    sys_clk,
   output logic [4:0]             osc_trim_value,
   output logic                   irq
);
   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   cfsm_pkg::cfsm_state_e state_reg, state_next;
   logic [10:0]           ost_reg;
   logic [5:0]            div_reg;
   logic                  seen_reg;
   logic                  ack_reg;
   logic [7:0]            flags_reg;
   logic [7:0]            enables_reg;
   logic [2:0]            freq_reg;
   logic                  sel_reg;
   logic [4:0]            trim_reg;
   logic [31:0]           rdata_reg;

   // ----------------------------------------------------------------
   // Bus decode
   // ----------------------------------------------------------------
   wire hit_flags = (address == {IDXB(cfsm_pkg::IDX_IRQ_FLAGS)});
   wire hit_en = (address == {IDXB(cfsm_pkg::IDX_IRQ_ENABLES)});
   wire hit_osc = (address == {IDXB(cfsm_pkg::IDX_OSC_CONTROL)});
   wire hit_trim = (address == {IDXB(cfsm_pkg::IDX_OSC_TRIM)});
   wire hit_cfg = (address == {IDXB(cfsm_pkg::IDX_CONFIG_WORD)});
   wire take = (read | write) & ack_reg;
   wire wr = write & take;
   wire rd_flags = read & take & hit_flags;
   wire sel_change = wr & hit_osc & (writedata[cfsm_pkg::SYS_SEL_BIT] != sel_reg);

   // Index to byte address
   function automatic logic [15:0] IDXB(input logic [15:0] idx);
      IDXB = {idx[13:0], 2'b00};
   endfunction : IDXB

   // Mode decode
   wire [2:0] src = cfg.word[2:0];
   wire crystal = (src == cfsm_pkg::LOW_POWER_CRYSTAL_MODE) |
                  (src == cfsm_pkg::STD_CRYSTAL_MODE) |
                  (src == cfsm_pkg::HIGH_SPEED_CRYSTAL_MODE);
   wire in_start = (state_reg == cfsm_pkg::ST_START);
   wire in_run = (state_reg == cfsm_pkg::ST_RUN);
   wire in_fail = (state_reg == cfsm_pkg::ST_FAIL);
   wire ost_done = (ost_reg == 11'(cfsm_pkg::OST_EDGES));
   // Sampler runs off the LF oscillator only once the external clock runs
   wire sample = in_run & lf_osc_tick &
                 (div_reg == 6'(cfsm_pkg::SAMPLE_DIV - 1));
   wire clk_fail = sample & cfg.fail_mon_en & ~seen_reg & ~sel_reg;

   // ----------------------------------------------------------------
   // Monitor state machine
   // ----------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         cfsm_pkg::ST_START: begin
            if (!crystal || ost_done) begin
               state_next = cfsm_pkg::ST_RUN;
            end
         end
         cfsm_pkg::ST_RUN: begin
            if (clk_fail) begin
               state_next = cfsm_pkg::ST_FAIL;
            end
         end
         cfsm_pkg::ST_FAIL: begin
            if (sel_change) begin
               state_next = cfsm_pkg::ST_START;
            end
         end
         cfsm_pkg::ST_SLEEP: begin
            if (wake_up) begin
               state_next = cfsm_pkg::ST_START;
            end
         end
         default: state_next = cfsm_pkg::ST_START;
      endcase
      if (sleep_exec) begin
         state_next = cfsm_pkg::ST_SLEEP;
      end
   end

   // State register; reset restarts start-up and leaves fail-safe
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         state_reg <= cfsm_pkg::ST_START;
      end else begin
         state_reg <= state_next;
      end
   end

   // Start-up counter of external clock edges, only in start-up
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ost_reg <= '0;
      end else if (!in_start) begin
         ost_reg <= '0;
      end else if (ext_clk_fall && !ost_done) begin
         ost_reg <= ost_reg + 11'd1;
      end
   end

   // Sample divider and monitoring latch
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_reg <= '0;
         seen_reg <= 1'b0;
      end else begin
         if (!in_run) begin
            div_reg <= '0;
         end else if (lf_osc_tick) begin
            div_reg <= div_reg + 6'd1;
         end
         if (!in_run || sample) begin
            seen_reg <= ext_clk_fall;
         end else if (ext_clk_fall) begin
            seen_reg <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Clock steering
   // ----------------------------------------------------------------
   // Internal clock when selected, in fail-safe or in two-speed start-up
   assign sys_clk.use_internal = sel_reg | in_fail |
                                 (in_start & crystal &
                                  (cfg.two_speed_en | cfg.fail_mon_en));
   assign sys_clk.hold = in_start & crystal & ~sel_reg &
                         ~(cfg.two_speed_en | cfg.fail_mon_en);
   assign sys_clk.freq = cfsm_pkg::cfsm_freq_e'(freq_reg);
   wire ext_active = in_run & ~sel_reg;
   assign osc_trim_value = trim_reg;

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   // Failure sets the flag; a read clears it only outside fail-safe
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         flags_reg <= cfsm_pkg::REG_RST;
      end else if (clk_fail) begin
         flags_reg[cfsm_pkg::OSC_FAIL_BIT] <= 1'b1;
      end else if (rd_flags && !in_fail) begin
         flags_reg[cfsm_pkg::OSC_FAIL_BIT] <= 1'b0;
      end
   end

   // Software writable fields
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         enables_reg <= cfsm_pkg::REG_RST;
         freq_reg <= cfsm_pkg::FREQ_RST;
         sel_reg <= 1'b0;
         trim_reg <= '0;
      end else if (wr) begin
         if (hit_en) begin
            enables_reg <= writedata[7:0];
         end
         if (hit_osc) begin
            freq_reg <= writedata[cfsm_pkg::FREQ_LSB +: 3];
            sel_reg <= writedata[cfsm_pkg::SYS_SEL_BIT];
         end
         if (hit_trim) begin
            trim_reg <= writedata[cfsm_pkg::TRIM_W - 1:0];
         end
      end
   end

   // Read mux
   wire [7:0] osc_rd = {1'b0, freq_reg, ext_active, hf_osc_ready,
                        lf_osc_ready, sel_reg};
   wire [7:0] rd_mux = hit_flags ? (flags_reg & 8'h04) :
                       hit_en ? enables_reg :
                       hit_osc ? osc_rd :
                       hit_trim ? {3'b000, trim_reg} :
                       hit_cfg ? cfg.word : 8'h00;

   // Avalon handshake: one wait state, data latched on the first edge
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         ack_reg <= 1'b0;
         rdata_reg <= '0;
      end else begin
         ack_reg <= (read | write) & ~ack_reg;
         if (read && !ack_reg) begin
            rdata_reg <= {24'h00_0000, rd_mux};
         end
      end
   end
   assign waitrequest = (read | write) & ~ack_reg;
   assign readdata = rdata_reg;

   // Level interrupt from unmasked flags
   assign irq = |(flags_reg & enables_reg);

   // ----------------------------------------------------------------
   // Assertions
   // ----------------------------------------------------------------
   sequence s_fail_write;
      in_fail && wr && hit_osc && !sel_change && !sleep_exec;
   endsequence

   sequence s_detect;
      clk_fail ##1 in_fail;
   endsequence

   AST_SLEEP_EXIT: assert property (@(posedge core_clk) disable iff (rst)
      sleep_exec |=> (state_reg == cfsm_pkg::ST_SLEEP))
      else $error("sleep did not leave fail-safe");
   AST_SEL_EXIT: assert property (@(posedge core_clk) disable iff (rst)
      (in_fail && sel_change && !sleep_exec) |=> in_start)
      else $error("select change did not leave fail-safe");
   AST_FAIL_INT: assert property (@(posedge core_clk) disable iff (rst)
      in_fail |-> sys_clk.use_internal)
      else $error("fail-safe without internal clock");
   AST_FREQ_KEEP: assert property (@(posedge core_clk) disable iff (rst)
      s_fail_write |=> (in_fail && freq_reg == $past(writedata[6:4])))
      else $error("frequency write broke fail-safe");
   AST_FLAG_HOLD: assert property (@(posedge core_clk) disable iff (rst)
      (in_fail && flags_reg[2]) |=> flags_reg[2])
      else $error("fail flag cleared in fail-safe");
   AST_NO_EARLY: assert property (@(posedge core_clk) disable iff (rst)
      $rose(in_fail) |-> $past(in_run))
      else $error("failure detected outside run");
   AST_EC_NOW: assert property (@(posedge core_clk) disable iff (rst)
      (in_start && !crystal && !sleep_exec) |=> in_run)
      else $error("monitoring did not start at once");
   AST_XTAL_INT: assert property (@(posedge core_clk) disable iff (rst)
      (in_start && crystal && cfg.fail_mon_en) |-> sys_clk.use_internal)
      else $error("crystal start-up not on internal clock");
   AST_EXT_CLOCK_ACTIVE_FLAG: assert property (@(posedge core_clk) disable iff (rst)
      osc_rd[3] |-> (!sys_clk.use_internal && !sys_clk.hold))
      else $error("ext active flag wrong");
   AST_RST_FREQ: assert property (@(posedge core_clk)
      $fell(rst) |-> (freq_reg == 3'b110 && !osc_rd[3]))
      else $error("reset values of control wrong");
   AST_DETECT: assert property (@(posedge core_clk) disable iff (rst)
      (s_detect and (!sleep_exec ##1 1)) |-> (flags_reg[2] ##1 irq == enables_reg[2]))
      else $error("failure not flagged");
   AST_FLAG_SET: assert property (@(posedge core_clk) disable iff (rst)
      clk_fail |=> flags_reg[2])
      else $error("failure did not set the flag");
   AST_FLAG_CLR: assert property (@(posedge core_clk) disable iff (rst)
      (rd_flags && !in_fail && !clk_fail) |=> !flags_reg[2])
      else $error("flag read outside fail-safe did not clear");
   AST_START_QUIET: assert property (@(posedge core_clk) disable iff (rst)
      in_start |=> !in_fail)
      else $error("failure detected during start-up");
   AST_SEL_INT: assert property (@(posedge core_clk) disable iff (rst)
      sel_reg |-> sys_clk.use_internal)
      else $error("select set without internal clock");
   AST_HF_FLAG: assert property (@(posedge core_clk) disable iff (rst)
      osc_rd[2] == hf_osc_ready)
      else $error("hf stable flag wrong");
endmodule : cfsm_monitor
`default_nettype wire

// ### verification/cfsm_ext_osc.sv
// External clock source model for the clock fail-safe monitor bench.
// Assumes core_clk at 10 MHz; both outputs are one-cycle pulses on core_clk.
`default_nettype none
module cfsm_ext_osc (
   // Clock and reset
   input  wire logic core_clk,
   input  wire logic rst,
   // Bench control: low stops the primary clock
   input  wire logic run,
   // Pulses towards the monitor
   output logic      ext_clk_fall,
   output logic      lf_osc_tick
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] div_reg;
   logic       lf_reg;
   // Primary edge every third cycle; LF oscillator runs free
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         div_reg <= 2'h0;
         lf_reg  <= 1'b0;
      end else begin
         div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
         lf_reg  <= ~lf_reg;
      end
   end
   // A stopped source gives no edges at all
   assign ext_clk_fall = run && (div_reg == 2'h2);
   assign lf_osc_tick  = lf_reg;
endmodule : cfsm_ext_osc
`default_nettype wire

// ### verification/tb_clock_fail_safe_monitor.sv
// Self-checking bench for cfsm_monitor over Avalon-MM.
// Assumes cfsm_pkg and cfsm_ext_osc are compiled first.
`default_nettype none
module tb_clock_fail_safe_monitor;
   timeunit 1ns;
   timeprecision 1ns;
   logic                core_clk, rst, read, write, waitrequest, irq, run;
   logic                ext_clk_fall, lf_osc_tick, hf_osc_ready, lf_osc_ready;
   logic                sleep_exec, wake_up;
   logic [15:0]         address;
   logic [31:0]         writedata, readdata;
   logic [4:0]          osc_trim_value;
   logic [7:0]          rd;
   cfsm_pkg::cfsm_cfg_s cfg;
   cfsm_pkg::cfsm_clk_s sys_clk;
   int                  n_errors, checks_done, i;
   // ----------------------------------------
   // Design, source model and clock
   // ----------------------------------------
   cfsm_monitor DUT (.core_clk(core_clk), .rst(rst), .address(address), .read(read),
      .write(write), .writedata(writedata), .readdata(readdata),
      .waitrequest(waitrequest), .ext_clk_fall(ext_clk_fall), .lf_osc_tick(lf_osc_tick),
      .hf_osc_ready(hf_osc_ready), .lf_osc_ready(lf_osc_ready), .sleep_exec(sleep_exec),
      .wake_up(wake_up), .cfg(cfg), .sys_clk(sys_clk), .osc_trim_value(osc_trim_value),
      .irq(irq));
   cfsm_ext_osc osc (.core_clk(core_clk), .rst(rst), .run(run),
      .ext_clk_fall(ext_clk_fall), .lf_osc_tick(lf_osc_tick));
   // 100 ns period
   always #50 core_clk = ~core_clk;
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task chk(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         n_errors++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk
   // One access; held until waitrequest is seen low at a rising edge
   task bus(input logic we, input logic [15:0] idx, input logic [7:0] wd,
            output logic [7:0] d);
      int n;
      @(posedge core_clk);
      address   <= {idx[13:0], 2'b00};
      read      <= ~we;
      write     <= we;
      writedata <= {24'h0, wd};
      n = 0;
      // Sampled at the rising edge, before that edge's updates land
      do begin
         @(posedge core_clk);
         n++;
      end while (waitrequest !== 1'b0 && n < 100);
      if (n >= 100) chk({7'h0, waitrequest}, 8'h00);
      d = readdata[7:0];
      read  <= 1'b0;
      write <= 1'b0;
   endtask : bus
   task rd_chk(input logic [15:0] idx, input logic [7:0] exp);
      bus(1'b0, idx, 8'h00, rd);
      chk(rd, exp);
   endtask : rd_chk
   task wr(input logic [15:0] idx, input logic [7:0] val);
      bus(1'b1, idx, val, rd);
   endtask : wr
   task wait_cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask : wait_cyc
   task wrap_up;
      if (n_errors == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : wrap_up
   // Watchdog well beyond the expected 7700 cycles
   initial begin
      repeat (50000) @(posedge core_clk);
      n_errors++;
      wrap_up();
   end
   // ----------------------------------------
   // Test sequence
   // ----------------------------------------
   initial begin
      core_clk = 0; rst = 1; read = 0; write = 0; address = 16'h0000;
      writedata = 32'h0000_0000; hf_osc_ready = 1; lf_osc_ready = 1;
      sleep_exec = 0; wake_up = 0; run = 0; n_errors = 0; checks_done = 0;
      cfg = '{two_speed_en: 1'b1, fail_mon_en: 1'b1, word: 8'h01};
      wait_cyc(6);
      rst <= 1'b0;
      // Reset values, HF stable flag, unmapped place
      rd_chk(cfsm_pkg::IDX_OSC_CONTROL, 8'h66);
      rd_chk(cfsm_pkg::IDX_IRQ_ENABLES, 8'h00);
      rd_chk(cfsm_pkg::IDX_OSC_TRIM, 8'h00);
      rd_chk(16'h0001, 8'h00);
      hf_osc_ready <= 1'b0;
      rd_chk(cfsm_pkg::IDX_OSC_CONTROL, 8'h62);
      hf_osc_ready <= 1'b1;
      // Silent crystal during start-up: no detection, internal clock
      wait_cyc(500);
      rd_chk(cfsm_pkg::IDX_IRQ_FLAGS, 8'h00);
      chk({7'h0, sys_clk.use_internal}, 8'h01);
      chk({7'h0, sys_clk.hold}, 8'h00);
      run <= 1'b1;
      wait_cyc(1024 * 3 + 20);
      rd_chk(cfsm_pkg::IDX_OSC_CONTROL, 8'h6e);
      chk({7'h0, sys_clk.use_internal}, 8'h00);
      // Primary clock fails with interrupt enabled
      wr(cfsm_pkg::IDX_IRQ_ENABLES, 8'h04);
      run <= 1'b0;
      wait_cyc(300);
      chk({7'h0, irq}, 8'h01);
      chk({7'h0, sys_clk.use_internal}, 8'h01);
      rd_chk(cfsm_pkg::IDX_IRQ_FLAGS, 8'h04);
      rd_chk(cfsm_pkg::IDX_IRQ_FLAGS, 8'h04);
      rd_chk(cfsm_pkg::IDX_OSC_CONTROL, 8'h66);
      // Every frequency code while fail-safe holds
      for (i = 0; i < 8; i++) begin
         wr(cfsm_pkg::IDX_OSC_CONTROL, {1'b0, 3'(i), 4'h0});
         wait_cyc(1);
         chk({5'h0, sys_clk.freq}, 8'(i));
      end
      chk({7'h0, sys_clk.use_internal}, 8'h01);
      // Changing the clock select ends fail-safe, flag then clears
      wr(cfsm_pkg::IDX_OSC_CONTROL, 8'h71);
      rd_chk(cfsm_pkg::IDX_IRQ_FLAGS, 8'h04);
      rd_chk(cfsm_pkg::IDX_IRQ_FLAGS, 8'h00);
      chk({7'h0, irq}, 8'h00);
      chk({7'h0, sys_clk.use_internal}, 8'h01);
      // Trim field width and write to the read-only config word
      wr(cfsm_pkg::IDX_OSC_TRIM, 8'hff);
      wr(cfsm_pkg::IDX_CONFIG_WORD, 8'h55);
      rd_chk(cfsm_pkg::IDX_OSC_TRIM, 8'h1f);
      chk({3'h0, osc_trim_value}, 8'h1f);
      rd_chk(cfsm_pkg::IDX_CONFIG_WORD, 8'h01);
      // External clock input mode: monitoring from the start
      cfg.word <= 8'h03;
      run      <= 1'b1;
      rst      <= 1'b1;
      wait_cyc(6);
      rst <= 1'b0;
      rd_chk(cfsm_pkg::IDX_OSC_CONTROL, 8'h6e);
      run <= 1'b0;
      wait_cyc(300);
      rd_chk(cfsm_pkg::IDX_IRQ_FLAGS, 8'h04);
      chk({7'h0, irq}, 8'h00);
      // Sleep ends fail-safe; wake-up restarts monitoring
      @(posedge core_clk);
      sleep_exec <= 1'b1;
      @(posedge core_clk);
      sleep_exec <= 1'b0;
      rd_chk(cfsm_pkg::IDX_IRQ_FLAGS, 8'h04);
      rd_chk(cfsm_pkg::IDX_IRQ_FLAGS, 8'h00);
      run     <= 1'b1;
      wake_up <= 1'b1;
      @(posedge core_clk);
      wake_up <= 1'b0;
      wait_cyc(20);
      rd_chk(cfsm_pkg::IDX_OSC_CONTROL, 8'h6e);
      // Crystal with neither two-speed nor monitor: clock held, no detection
      cfg <= '{two_speed_en: 1'b0, fail_mon_en: 1'b0, word: 8'h01};
      rst <= 1'b1;
      wait_cyc(6);
      rst <= 1'b0;
      wait_cyc(2);
      chk({7'h0, sys_clk.hold}, 8'h01);
      chk({7'h0, sys_clk.use_internal}, 8'h00);
      wait_cyc(1024 * 3 + 20);
      chk({7'h0, sys_clk.hold}, 8'h00);
      run <= 1'b0;
      wait_cyc(300);
      rd_chk(cfsm_pkg::IDX_IRQ_FLAGS, 8'h00);
      rd_chk(cfsm_pkg::IDX_OSC_CONTROL, 8'h6e);
      wrap_up();
   end
endmodule : tb_clock_fail_safe_monitor
`default_nettype wire
